// ==== src/fepc_dev.sv ====
//==============================================================================
// fepc_dev - erase and power-down command logic of the flash end
//==============================================================================
// Purpose: decode wipe, unlock, sleep and wake frames, time the cycles
// Assumes: NRST is the power-on reset; link pins are asynchronous
// Notes:   array erase itself is requested on WIPE_GO, timing is internal
module fepc_dev
	import fepc_pkg::*;
#(
	parameter int INHIBIT_CYCLES = INHIBIT_CYC
) (
	input  wire logic       CLK,
	input  wire logic       NRST,
	fepc_if.dev             LINK,
	input  wire logic [2:0] BLOCK_PROTECT,
	output logic            WIPE_GO,
	output logic            WIPE_ALL,
	output logic [5:0]      WIPE_SECTOR,
	output logic            BUSY,
	output logic            WRITE_ENABLE_LATCH,
	output logic            STANDBY,
	output logic            SLEEPING
);
	typedef enum logic [1:0] {MD_STBY, MD_ENTER, MD_SLEEP, MD_WAKE} fepc_mode_e;

	//==========================================================================
	// link sampling
	//==========================================================================
	logic [2:0]       pins_s;
	logic             cs_s;
	logic             sck_s;
	logic             si_s;
	logic             cs_prev_reg;
	logic             sck_prev_reg;

	fepc_sync #(.W(3)) u_sync (
		.CLK  (CLK),
		.NRST (NRST),
		.D    ({~LINK.s_n, LINK.sck, LINK.serial_in_line}),
		.Q    (pins_s)
	);
	// select is carried inverted so the flops' reset level reads as deselected
	assign cs_s  = ~pins_s[2];
	assign sck_s = pins_s[1];
	assign si_s  = pins_s[0];

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cs_prev_reg  <= 1'b1;
			sck_prev_reg <= 1'b0;
		end else begin
			cs_prev_reg  <= cs_s;
			sck_prev_reg <= sck_s;
		end
	end

	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	assign cs_rise  = cs_s & ~cs_prev_reg;
	assign sck_rise = ~cs_s & sck_s & ~sck_prev_reg;
	assign sck_fall = ~cs_s & ~sck_s & sck_prev_reg;

	//==========================================================================
	// frame shifter
	//==========================================================================
	logic [5:0]       bit_cnt_reg;
	logic [31:0]      shift_reg;
	logic [31:0]      shift_next;
	logic [7:0]       so_shift_reg;
	fepc_mode_e       mode_reg;
	logic             busy_reg;
	logic             wel_reg;
	logic             inhibit_done_reg;

	assign shift_next = {shift_reg[30:0], si_s};

	// bit count saturates so any overlong frame never matches a legal length
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			bit_cnt_reg <= 6'h00;
			shift_reg   <= 32'h00000000;
		end else if (cs_s) begin
			bit_cnt_reg <= 6'h00;
		end else if (sck_rise) begin
			shift_reg <= shift_next;
			if (bit_cnt_reg != 6'h3f) begin
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			end
		end
	end

	function automatic logic [7:0] status_byte(input logic [2:0] bp, input logic write_enable_latch,
			input logic busy);
		logic [7:0] s;
		s = 8'h00;
		s[ST_BUSY] = busy;
		s[ST_WEL] = write_enable_latch;
		s[ST_BP_LSB +: 3] = bp;
		return s;
	endfunction

	function automatic logic [7:0] lock_byte();
		logic [7:0] l;
		l = 8'h00;
		l[LK_DOWN] = LOCK_DOWN_RST;
		l[LK_WRITE] = WRITE_LOCK_RST;
		return l;
	endfunction

	// read data only while awake; asleep the output stays low
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			so_shift_reg    <= 8'h00;
			LINK.serial_out <= 1'b0;
		end else if (sck_rise && mode_reg == MD_STBY) begin
			if (bit_cnt_reg == LEN_OPCODE - 6'h01 && shift_next[7:0] == OP_RD_STATUS) begin
				so_shift_reg <= status_byte(BLOCK_PROTECT, wel_reg, busy_reg);
			end else if (bit_cnt_reg == LEN_ADDR - 6'h01 && shift_next[31:24] == OP_RD_LOCK) begin
				so_shift_reg <= lock_byte();
			end
		end else if (sck_fall) begin
			LINK.serial_out <= so_shift_reg[7];
			so_shift_reg    <= {so_shift_reg[6:0], 1'b0};
		end
	end

	//==========================================================================
	// decode at select rise
	//==========================================================================
	function automatic logic sector_protected(input logic [2:0] bp, input logic [5:0] sect);
		logic [6:0] first;
		first = 7'h40 - (7'h01 << (bp - 3'h1));
		if (bp == 3'h0) begin
			return 1'b0;
		end
		return ({1'b0, sect} >= first) || (bp == 3'h7);
	endfunction

	logic       len8;
	logic       len32;
	logic       can_write;
	logic [5:0] sector;
	logic       do_unlock;
	logic       do_all;
	logic       do_blk;
	logic       do_sleep;
	logic       do_wake;

	assign len8      = cs_rise && bit_cnt_reg == LEN_OPCODE;
	assign len32     = cs_rise && bit_cnt_reg == LEN_ADDR;
	assign sector    = shift_reg[SECT_LSB +: 6];
	assign can_write = mode_reg == MD_STBY && !busy_reg && inhibit_done_reg;
	assign do_unlock = len8 && shift_reg[7:0] == OP_UNLOCK && can_write;
	assign do_all    = len8 && shift_reg[7:0] == OP_WIPE_ALL && can_write && wel_reg
			&& BLOCK_PROTECT == 3'h0;
	assign do_blk    = len32 && shift_reg[31:24] == OP_WIPE_BLK && can_write && wel_reg
			&& !sector_protected(BLOCK_PROTECT, sector);
	assign do_sleep  = len8 && shift_reg[7:0] == OP_SLEEP && mode_reg == MD_STBY
			&& !busy_reg;
	assign do_wake   = len8 && shift_reg[7:0] == OP_WAKE && mode_reg == MD_SLEEP
			&& !busy_reg;

	//==========================================================================
	// power-up write inhibit
	//==========================================================================
	logic [INH_W-1:0] inh_cnt_reg;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			inh_cnt_reg      <= '0;
			inhibit_done_reg <= 1'b0;
		end else if (!inhibit_done_reg) begin
			inh_cnt_reg <= inh_cnt_reg + 1'b1;
			if (inh_cnt_reg == INH_W'(INHIBIT_CYCLES - 1)) begin
				inhibit_done_reg <= 1'b1;
			end
		end
	end

	//==========================================================================
	// self-timed wipe cycle
	//==========================================================================
	logic [CNT_W-1:0] wipe_cnt_reg;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			busy_reg     <= 1'b0;
			wipe_cnt_reg <= '0;
			WIPE_GO      <= 1'b0;
			WIPE_ALL     <= 1'b0;
			WIPE_SECTOR  <= 6'h00;
		end else begin
			WIPE_GO <= 1'b0;
			if (do_all || do_blk) begin
				busy_reg     <= 1'b1;
				wipe_cnt_reg <= '0;
				WIPE_GO      <= 1'b1;
				WIPE_ALL     <= do_all;
				WIPE_SECTOR  <= do_all ? 6'h00 : sector;
			end else if (busy_reg) begin
				wipe_cnt_reg <= wipe_cnt_reg + 1'b1;
				if (wipe_cnt_reg == (WIPE_ALL ? CNT_W'(WIPE_ALL_CYC - 1)
						: CNT_W'(WIPE_BLK_CYC - 1))) begin
					busy_reg <= 1'b0;
				end
			end
		end
	end

	// latch drops at cycle start, well before the cycle ends
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wel_reg <= 1'b0;
		end else if (do_unlock) begin
			wel_reg <= 1'b1;
		end else if (do_all || do_blk) begin
			wel_reg <= 1'b0;
		end
	end

	//==========================================================================
	// power mode
	//==========================================================================
	logic [CNT_W-1:0] mode_cnt_reg;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			mode_reg     <= MD_STBY;
			mode_cnt_reg <= '0;
		end else begin
			mode_cnt_reg <= mode_cnt_reg + 1'b1;
			case (mode_reg)
				MD_STBY: begin
					if (do_sleep) begin
						mode_reg     <= MD_ENTER;
						mode_cnt_reg <= '0;
					end
				end
				MD_ENTER: begin
					if (mode_cnt_reg == CNT_W'(SLEEP_ENTRY_CYC - 1)) begin
						mode_reg <= MD_SLEEP;
					end
				end
				MD_SLEEP: begin
					if (do_wake) begin
						mode_reg     <= MD_WAKE;
						mode_cnt_reg <= '0;
					end
				end
				MD_WAKE: begin
					if (mode_cnt_reg == CNT_W'(WAKE_CYC - 1)) begin
						mode_reg <= MD_STBY;
					end
				end
				default: mode_reg <= MD_STBY;
			endcase
		end
	end

	//==========================================================================
	// user-side status
	//==========================================================================
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			BUSY     <= 1'b0;
			WRITE_ENABLE_LATCH      <= 1'b0;
			STANDBY  <= 1'b0;
			SLEEPING <= 1'b0;
		end else begin
			BUSY     <= busy_reg;
			WRITE_ENABLE_LATCH      <= wel_reg;
			STANDBY  <= cs_s && !busy_reg && mode_reg == MD_STBY;
			SLEEPING <= mode_reg == MD_SLEEP;
		end
	end
endmodule

// ==== src/fepc_pkg.sv ====
//==============================================================================
// fepc_pkg - shared constants for the erase and power command link
//==============================================================================
// Purpose: opcodes, frame lengths, status layout and timing counts
// Assumes: CLK at 40 MHz, link in clock mode 0, MSB first
// Notes:   opcode values and cycle durations are plain defaults
package fepc_pkg;

	localparam logic [7:0] OP_UNLOCK    = 8'h1a;
	localparam logic [7:0] OP_WIPE_BLK  = 8'h2b;
	localparam logic [7:0] OP_WIPE_ALL  = 8'h3c;
	localparam logic [7:0] OP_SLEEP     = 8'h4d;
	localparam logic [7:0] OP_WAKE      = 8'h5e;
	localparam logic [7:0] OP_RD_STATUS = 8'h6f;
	localparam logic [7:0] OP_RD_LOCK   = 8'h70;

	localparam logic [5:0] LEN_OPCODE   = 6'h08;
	localparam logic [5:0] LEN_ADDR     = 6'h20;
	localparam logic [5:0] LEN_RD_STAT  = 6'h10;
	localparam logic [5:0] LEN_RD_LOCK  = 6'h28;

	localparam int ST_BUSY   = 0;
	localparam int ST_WEL    = 1;
	localparam int ST_BP_LSB = 2;
	localparam int SECT_LSB  = 16;
	localparam int LK_DOWN   = 1;
	localparam int LK_WRITE  = 0;
	localparam logic LOCK_DOWN_RST  = 1'b0;
	localparam logic WRITE_LOCK_RST = 1'b0;

	localparam int CLK_NS                   = 25;
	localparam int SLEEP_ENTRY_DELAY_NS     = 3000;
	localparam int WAKE_DELAY_NS            = 3000;
	localparam int WRITE_INHIBIT_DELAY_MS   = 1;
	localparam int SELECT_AFTER_POWER_DELAY_US = 30;
	localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_CYC        = (WAKE_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int INHIBIT_CYC     = (WRITE_INHIBIT_DELAY_MS * 1000000) / CLK_NS;
	localparam int SELECT_CYC      = (SELECT_AFTER_POWER_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int WIPE_BLK_CYC    = 2000;
	localparam int WIPE_ALL_CYC    = 4000;
	localparam int INH_W           = 19;
	localparam int CNT_W           = 16;

	localparam logic [3:0]  SCK_HALF_CYC = 4'h8;
	localparam int          SYNC_MARGIN  = 4;
	localparam logic [CNT_W-1:0] GAP_CYC = 16'h0010;

endpackage

// ==== src/fepc_if.sv ====
//==============================================================================
// fepc_if - serial link between host controller and flash command logic
//==============================================================================
// Purpose: carries select, serial clock, serial in and serial out
// Assumes: host makes the clock; all wires single direction
// Notes:   no tristate, serial out is always driven
interface fepc_if;
	logic s_n;
	logic sck;
	logic serial_in_line;
	logic serial_out;

	modport dev (
		input  s_n,
		input  sck,
		input  serial_in_line,
		output serial_out
	);

	modport host (
		output s_n,
		output sck,
		output serial_in_line,
		input  serial_out
	);
endinterface

// ==== src/fepc_sync.sv ====
//==============================================================================
// fepc_sync - two flop synchroniser for asynchronous levels
//==============================================================================
// Purpose: bring link pins into the CLK domain
// Assumes: inputs change slower than CLK
// Notes:   only Q may be read by other logic
module fepc_sync #(
	parameter int W = 1
) (
	input  wire logic         CLK,
	input  wire logic         NRST,
	input  wire logic [W-1:0] D,
	output logic      [W-1:0] Q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			meta_reg <= '0;
			Q        <= '0;
		end else begin
			meta_reg <= D;
			Q        <= meta_reg;
		end
	end
endmodule

// ==== src/fepc_host.sv ====
//==============================================================================
// fepc_host - host controller issuing erase and power frames
//==============================================================================
// Purpose: shift one command per request, poll busy before writes
// Assumes: one command in flight; link clock made by divider
// Notes:   link clock period is 2 x SCK_HALF_CYC CLK cycles
module fepc_host
	import fepc_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        NRST,
	fepc_if.host             LINK,
	input  wire logic        CMD_VALID,
	output logic             CMD_READY,
	input  wire logic [7:0]  CMD_OP,
	input  wire logic [23:0] CMD_ADDR,
	output logic             RSP_VALID,
	output logic [7:0]       RSP_DATA
);
	typedef enum logic [2:0] {HS_PWR, HS_IDLE, HS_START, HS_SHIFT, HS_GAP} fepc_hstate_e;

	function automatic logic [11:0] frame_shape(input logic [7:0] op);
		case (op)
			OP_WIPE_BLK:  return {LEN_ADDR, LEN_ADDR};
			OP_RD_STATUS: return {LEN_OPCODE, LEN_RD_STAT};
			OP_RD_LOCK:   return {LEN_ADDR, LEN_RD_LOCK};
			default:      return {LEN_OPCODE, LEN_OPCODE};
		endcase
	endfunction

	function automatic logic needs_poll(input logic [7:0] op);
		return op == OP_UNLOCK || op == OP_WIPE_ALL || op == OP_WIPE_BLK;
	endfunction

	logic             so_s;
	fepc_hstate_e     state_reg;
	logic [7:0]       op_reg;
	logic [23:0]      addr_reg;
	logic             poll_reg;
	logic [31:0]      tx_reg;
	logic [7:0]       rx_reg;
	logic [5:0]       tx_bits_reg;
	logic [5:0]       len_reg;
	logic [5:0]       cnt_reg;
	logic [3:0]       div_reg;
	logic [CNT_W-1:0] wait_reg;
	logic [7:0]       cur_op;

	fepc_sync #(.W(1)) u_sync (
		.CLK  (CLK),
		.NRST (NRST),
		.D    (LINK.serial_out),
		.Q    (so_s)
	);

	assign cur_op = poll_reg ? OP_RD_STATUS : op_reg;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg           <= HS_PWR;
			op_reg              <= 8'h00;
			addr_reg            <= 24'h000000;
			poll_reg            <= 1'b0;
			tx_reg              <= 32'h00000000;
			rx_reg              <= 8'h00;
			tx_bits_reg         <= 6'h00;
			len_reg             <= 6'h00;
			cnt_reg             <= 6'h00;
			div_reg             <= 4'h0;
			wait_reg            <= '0;
			CMD_READY           <= 1'b0;
			RSP_VALID           <= 1'b0;
			RSP_DATA            <= 8'h00;
			LINK.s_n            <= 1'b1;
			LINK.sck            <= 1'b0;
			LINK.serial_in_line <= 1'b0;
		end else begin
			RSP_VALID <= 1'b0;
			case (state_reg)
				HS_PWR: begin
					wait_reg <= wait_reg + 1'b1;
					if (wait_reg == CNT_W'(SELECT_CYC - 1)) begin
						state_reg <= HS_IDLE;
						CMD_READY <= 1'b1;
					end
				end
				HS_IDLE: begin
					if (CMD_VALID) begin
						CMD_READY <= 1'b0;
						op_reg    <= CMD_OP;
						addr_reg  <= CMD_ADDR;
						poll_reg  <= needs_poll(CMD_OP);
						state_reg <= HS_START;
					end
				end
				HS_START: begin
					{tx_bits_reg, len_reg} <= frame_shape(cur_op);
					tx_reg              <= {cur_op, poll_reg ? 24'h000000 : addr_reg};
					LINK.serial_in_line <= cur_op[7];
					LINK.s_n            <= 1'b0;
					cnt_reg             <= 6'h00;
					div_reg             <= 4'h0;
					state_reg           <= HS_SHIFT;
				end
				HS_SHIFT: begin
					div_reg <= div_reg + 4'h1;
					if (div_reg == SCK_HALF_CYC - 4'h1) begin
						div_reg  <= 4'h0;
						LINK.sck <= ~LINK.sck;
						if (!LINK.sck) begin
							if (cnt_reg >= tx_bits_reg) begin
								rx_reg <= {rx_reg[6:0], so_s};
							end
							cnt_reg <= cnt_reg + 6'h01;
						end else begin
							tx_reg              <= {tx_reg[30:0], 1'b0};
							LINK.serial_in_line <= tx_reg[30];
							if (cnt_reg == len_reg) begin
								LINK.s_n  <= 1'b1;
								wait_reg  <= '0;
								state_reg <= HS_GAP;
							end
						end
					end
				end
				HS_GAP: begin
					wait_reg <= wait_reg + 1'b1;
					// wake guard also covers the device's pin sampling lag
					if ((cur_op == OP_WAKE && wait_reg == CNT_W'(WAKE_CYC + SYNC_MARGIN))
							|| (cur_op != OP_WAKE && wait_reg == GAP_CYC)) begin
						if (poll_reg && !rx_reg[ST_BUSY]) begin
							poll_reg  <= 1'b0;
							state_reg <= HS_START;
						end else if (poll_reg) begin
							state_reg <= HS_START;
						end else begin
							RSP_VALID <= len_reg != tx_bits_reg;
							RSP_DATA  <= rx_reg;
							CMD_READY <= 1'b1;
							state_reg <= HS_IDLE;
						end
					end
				end
				default: state_reg <= HS_IDLE;
			endcase
		end
	end
endmodule

// ==== tb/fepc_monitor.sv ====
//==============================================================================
// fepc_monitor - checks on the link and the flash end outputs
//==============================================================================
// Purpose: concurrent checks beside the main link
// Assumes: one CLK domain, NRST async active low
// Notes:   protect decode is top 2^(n-1) of 64 sectors
module fepc_monitor (
	input wire logic       CLK,
	input wire logic       NRST,
	input wire logic       s_n,
	input wire logic       sck,
	input wire logic [2:0] BLOCK_PROTECT,
	input wire logic       WIPE_GO,
	input wire logic       WIPE_ALL,
	input wire logic [5:0] WIPE_SECTOR,
	input wire logic       BUSY,
	input wire logic       WRITE_ENABLE_LATCH,
	input wire logic       STANDBY,
	input wire logic       SLEEPING
);
	logic [15:0] busy_cnt;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	//==========================================================================
	// busy length counter
	//==========================================================================
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			busy_cnt <= 16'h0000;
		else if (WIPE_GO)
			busy_cnt <= 16'h0000;
		else if (BUSY)
			busy_cnt <= busy_cnt + 16'h0001;
	end

	//==========================================================================
	// checks
	//==========================================================================
	AST_SCK_SEL: assert property ($rose(sck) |-> !s_n)
		else $error("serial clock rose while deselected");
	AST_GO_PULSE: assert property (WIPE_GO |=> !WIPE_GO)
		else $error("wipe start pulse longer than one cycle");
	AST_GO_SEL: assert property (WIPE_GO |-> s_n && $past(s_n, 3))
		else $error("wipe started while selected");
	AST_BUSY_START: assert property (WIPE_GO |=> BUSY && !WRITE_ENABLE_LATCH)
		else $error("busy or latch wrong after wipe start");
	AST_BUSY_LEN: assert property ($fell(BUSY) |->
		busy_cnt == (WIPE_ALL ? 16'h0fa0 : 16'h07d0))
		else $error("busy length wrong");
	AST_PROT_ALL: assert property (WIPE_GO ##1 WIPE_ALL |-> $past(BLOCK_PROTECT) == 3'h0)
		else $error("whole array wipe with protection set");
	AST_PROT_BLK: assert property (WIPE_GO ##1 !WIPE_ALL |-> $past(BLOCK_PROTECT) == 3'h0
		|| {1'b0, WIPE_SECTOR} < 7'h40 - (7'h01 << ($past(BLOCK_PROTECT) - 3'h1)))
		else $error("protected sector wiped");
	AST_SLEEP_ENTRY: assert property ($rose(SLEEPING) |-> s_n && $past(s_n, 100))
		else $error("sleep entered too early");
	AST_SLEEP_QUIET: assert property (SLEEPING |-> !BUSY && !STANDBY)
		else $error("activity while asleep");
	AST_WAKE: assert property ($fell(SLEEPING) |-> ##[110:130] STANDBY)
		else $error("no standby after wake delay");
endmodule

// ==== tb/flash_erase_power_cmds_test.sv ====
//==============================================================================
// flash_erase_power_cmds_test - host end driving flash end, plus a bench link
//==============================================================================
// Purpose: erase, protect, sleep and wake sequences at the user ports
// Assumes: second flash end is driven by the bench to break framing
// Notes:   inhibit counts shortened so power-up lockout is visible
module flash_erase_power_cmds_test;
	timeunit 1ns;
	timeprecision 1ps;
	import fepc_pkg::*;

	localparam int INH  = 50;
	localparam int INH2 = 200;

	logic        clk, nrst, cmd_valid, cmd_ready, rsp_valid;
	logic [7:0]  cmd_op, rsp_data;
	logic [23:0] cmd_addr;
	logic [2:0]  bp;
	logic        go, all, busy, write_enable_latch, stby, slp, go2, wel2, slp2;
	logic [5:0]  sect;
	int          err_count, n_checks, go_cnt, go2_cnt, cyc;

	fepc_if lnk ();
	fepc_if lnk2 ();

	fepc_host u_fepc_host (.CLK(clk), .NRST(nrst), .LINK(lnk.host), .CMD_VALID(cmd_valid),
		.CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr),
		.RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
	fepc_dev #(.INHIBIT_CYCLES(INH)) u_fepc_dev (.CLK(clk), .NRST(nrst), .LINK(lnk.dev),
		.BLOCK_PROTECT(bp), .WIPE_GO(go), .WIPE_ALL(all), .WIPE_SECTOR(sect),
		.BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .STANDBY(stby), .SLEEPING(slp));
	// bench-driven end: protect tied off, only power-up lockout and framing faults matter here
	fepc_dev #(.INHIBIT_CYCLES(INH2)) u_fepc_dev_2 (.CLK(clk), .NRST(nrst), .LINK(lnk2.dev),
		.BLOCK_PROTECT(3'h0), .WIPE_GO(go2), .WIPE_ALL(), .WIPE_SECTOR(),
		.BUSY(), .WRITE_ENABLE_LATCH(wel2), .STANDBY(), .SLEEPING(slp2));
	fepc_monitor u_fepc_monitor (.CLK(clk), .NRST(nrst), .s_n(lnk.s_n), .sck(lnk.sck),
		.BLOCK_PROTECT(bp), .WIPE_GO(go), .WIPE_ALL(all), .WIPE_SECTOR(sect),
		.BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .STANDBY(stby), .SLEEPING(slp));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		go_cnt <= go_cnt + int'(go === 1'b1);
		go2_cnt <= go2_cnt + int'(go2 === 1'b1);
		if (cyc == 80000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic cmd(input logic [7:0] op, input logic [23:0] a);
		wait_ready();
		cmd_op <= op;
		cmd_addr <= a;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		repeat (2) @(posedge clk);
		wait_ready();
	endtask

	task automatic st(input logic [7:0] exp);
		cmd(OP_RD_STATUS, 24'h000000);
		chk({rsp_valid, rsp_data}, {1'b1, exp});
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
	endtask

	// bit count of the frame is nb; the low nb bits of v are sent, MSB first
	task automatic frame(input logic [31:0] v, input int nb);
		lnk2.s_n <= 1'b0;
		for (int i = nb - 1; i >= 0; i--) begin
			lnk2.serial_in_line <= v[i];
			repeat (4) @(posedge clk);
			lnk2.sck <= 1'b1;
			repeat (4) @(posedge clk);
			lnk2.sck <= 1'b0;
		end
		repeat (4) @(posedge clk);
		lnk2.s_n <= 1'b1;
		lnk2.serial_in_line <= ~v[0];
		repeat (8) @(posedge clk);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		nrst = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 8'h00;
		cmd_addr = 24'h000000;
		bp = 3'h0;
		lnk2.s_n = 1'b1;
		lnk2.sck = 1'b0;
		lnk2.serial_in_line = 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		//======================================================================
		// bench link: lockout and framing faults
		//======================================================================
		frame({24'h0, OP_UNLOCK}, 8);
		chk(wel2, 1'b0);
		repeat (100) @(posedge clk);
		frame({24'h0, OP_UNLOCK}, 8);
		chk(wel2, 1'b1);
		frame({8'h0, OP_WIPE_BLK, 16'h0100}, 24);
		frame({23'h0, OP_WIPE_ALL, 1'b0}, 9);
		chk(go2_cnt, 0);
		chk(wel2, 1'b1);
		frame({25'h0, OP_SLEEP[7:1]}, 7);
		repeat (130) @(posedge clk);
		chk(slp2, 1'b0);
		frame({24'h0, OP_SLEEP}, 8);
		repeat (130) @(posedge clk);
		chk(slp2, 1'b1);
		frame({23'h0, OP_WAKE, 1'b1}, 9);
		repeat (130) @(posedge clk);
		chk(slp2, 1'b1);
		frame({24'h0, OP_WAKE}, 8);
		repeat (130) @(posedge clk);
		chk(slp2, 1'b0);
		$display("test framing done");
		//======================================================================
		// host link: block wipe, refusals while busy
		//======================================================================
		st(8'h00);
		chk(stby, 1'b1);
		cmd(OP_WIPE_BLK, 24'h3a5678);
		chk(go_cnt, 0);
		cmd(OP_UNLOCK, 24'h000000);
		st(8'h02);
		cmd(OP_WIPE_BLK, 24'h3a5678);
		chk({all, sect}, 7'h3a);
		st(8'h01);
		cmd(OP_SLEEP, 24'h000000);
		repeat (130) @(posedge clk);
		cmd(OP_WAKE, 24'h000000);
		chk({slp, busy}, 2'h1);
		wait_idle();
		st(8'h00);
		$display("test block wipe done");
		//======================================================================
		// host link: protection
		//======================================================================
		bp <= 3'h1;
		cmd(OP_UNLOCK, 24'h000000);
		cmd(OP_WIPE_BLK, 24'h3fffff);
		cmd(OP_WIPE_ALL, 24'h000000);
		chk(go_cnt, 1);
		st(8'h06);
		cmd(OP_WIPE_BLK, 24'h3e0000);
		chk({go_cnt[1:0], sect}, 8'hbe);
		wait_idle();
		bp <= 3'h0;
		cmd(OP_UNLOCK, 24'h000000);
		cmd(OP_WIPE_ALL, 24'h000000);
		chk({go_cnt[1:0], all, sect}, 9'h1c0);
		wait_idle();
		$display("test protect done");
		//======================================================================
		// host link: sleep and wake
		//======================================================================
		cmd(OP_UNLOCK, 24'h000000);
		cmd(OP_SLEEP, 24'h000000);
		repeat (130) @(posedge clk);
		chk({slp, stby}, 2'h2);
		cmd(OP_WIPE_ALL, 24'h000000);
		chk(go_cnt, 3);
		cmd(OP_WAKE, 24'h000000);
		chk({slp, stby}, 2'h1);
		chk(write_enable_latch, 1'b1);
		cmd(OP_RD_LOCK, 24'h000000);
		chk({rsp_valid, rsp_data}, 9'h100);
		$display("test sleep done");
		stop_test();
	end
endmodule
